// ---- rtl/timer8_map.svh ----
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH

// register byte addresses on the plain register port
`define TMR_OFS_CTRL_A   8'h24
`define TMR_OFS_CTRL_B   8'h25
`define TMR_OFS_COUNT    8'h26
`define TMR_OFS_CMP_A    8'h27
`define TMR_OFS_CMP_B    8'h28
`define TMR_OFS_FLAGS    8'h29

// field positions in control register a
`define TMR_CA_ACT_A_HI  7
`define TMR_CA_ACT_A_LO  6
`define TMR_CA_ACT_B_HI  5
`define TMR_CA_ACT_B_LO  4
`define TMR_CA_WGM_HI    1
`define TMR_CA_WGM_LO    0

// field positions in control register b
`define TMR_CB_FORCE_A   7
`define TMR_CB_FORCE_B   6
`define TMR_CB_WGM2      3
`define TMR_CB_CS_HI     2
`define TMR_CB_CS_LO     0

// flag register bit positions
`define TMR_FL_MATCH_B   2
`define TMR_FL_MATCH_A   1
`define TMR_FL_OVF       0

// counter limits
`define TMR_MAX          8'hff
`define TMR_BOTTOM       8'h00

// reset values
`define TMR_RST_BYTE     8'h00
`define TMR_RST_FLAGS    3'h0

// waveform mode codes
`define TMR_WGM_NORMAL   3'h0
`define TMR_WGM_PC_FF    3'h1
`define TMR_WGM_CTC      3'h2
`define TMR_WGM_FAST_FF  3'h3
`define TMR_WGM_PC_A     3'h5
`define TMR_WGM_FAST_A   3'h7

// clock select codes
`define TMR_CS_STOP      3'h0
`define TMR_CS_DIV1      3'h1
`define TMR_CS_DIV8      3'h2
`define TMR_CS_DIV64     3'h3
`define TMR_CS_DIV256    3'h4
`define TMR_CS_DIV1024   3'h5
`define TMR_CS_EXT_FALL  3'h6
`define TMR_CS_EXT_RISE  3'h7

// prescaler taps, as log2 of the division
`define TMR_PRE_BITS     10
`define TMR_DIV8_BITS    3
`define TMR_DIV64_BITS   6
`define TMR_DIV256_BITS  8
`define TMR_DIV1024_BITS 10

`endif

// ---- rtl/timer8_pkg.sv ----
package timer8_pkg;

	// counting direction of the dual-slope modes
	typedef enum logic [0:0] {
		CNT_UP   = 1'b0,
		CNT_DOWN = 1'b1
	} count_dir_type;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;

	// stored control fields
	typedef struct packed {
		logic [1:0] out_action_a;
		logic [1:0] out_action_b;
		logic [2:0] waveform_mode_sel;
		logic [2:0] clock_source_sel;
	} ctrl_type;

	// whole block state
	typedef struct packed {
		ctrl_type      ctrl;
		logic [7:0]    counter_value;
		logic [7:0]    cmp_a_buf;
		logic [7:0]    cmp_b_buf;
		logic [7:0]    cmp_a;
		logic [7:0]    cmp_b;
		count_dir_type dir;
		logic          block;
		logic [2:0]    flags;
		logic          wave_a;
		logic          wave_b;
		logic          oe_a;
		logic          oe_b;
		logic [9:0]    pre;
		logic [2:0]    ext_sync;
		logic [7:0]    rdata;
	} state_type;

endpackage

// ---- rtl/timer8_compare_pwm_unit.sv ----
`include "timer8_map.svh"

// Function
// (R1) nonzero action b overrides port; driver enabled only with pin direction set
// (R2) non-pwm action b: 00 off, 01 toggle, 10 clear, 11 set on match
// (R3) fast pwm b: 10 clear match/set bottom, 11 inverse, 01 reserved
// (R4) phase pwm b: 10 clear on up match, set on down match; 11 inverse
// (R5) pwm with compare b at top and action bit1: match ignored, act at top
// (R6) reserved control bits read as zero
// (R7) three-bit waveform mode split over control a and control b
// (R8) normal top ff, ctc top compare a; immediate update; overflow at max
// (R9) phase modes update at top, flag bottom; fast update bottom, flag max/top
// (R10) modes 4 and 6 reserved; max is ff, bottom is 00
// (R11) force strobe applies configured action in non-pwm modes only
// (R12) force sets no flag, never clears counter, reads as zero
// (R13) software writes zero force bits while in pwm mode
// (R14) clock select 0 stops; 1..5 divide by 1, 8, 64, 256, 1024
// (R15) select 6 counts falling, 7 rising edges of external count pin
// (R16) external edges count even when the pin is an output
// (R17) counter register has direct read and write access
// (R18) counter write suppresses compare match on next timer tick
// (R19) compare levels compared continuously; match sets flag and drives wave
// (R20) flags set on events, cleared by vector acknowledge or write one
// (R21) phase mode counts up to top, holds one tick, then counts down; the code has no hold and goes from top straight to top - 1
// (R22) count pin synchronised, edge detected; source gives one-cycle enable
module timer8_compare_pwm_unit (
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	// register port
	input  wire timer8_pkg::bus_req_type bus_i,
	output logic      [7:0]           rd_data_o,
	// pin side
	input  wire logic                 ext_count_in_i,
	input  wire logic                 pin_dir_a_i,
	input  wire logic                 pin_dir_b_i,
	output logic                      wave_out_a_o,
	output logic                      wave_out_b_o,
	output logic                      wave_oe_a_o,
	output logic                      wave_oe_b_o,
	// event flags and their vector acknowledge
	input  wire logic      [2:0]      vec_ack_i,
	output logic      [2:0]           flags_o
);

	timer8_pkg::state_type s_q;
	timer8_pkg::state_type s_d;

	// helper signals shared by the logic and its checks
	logic       tick;
	logic [7:0] top;
	logic       at_top;
	logic       match_a;
	logic       match_b;
	logic       force_a;
	logic       force_b;
	logic       wr_cnt;
	logic       ext_rise;
	logic       ext_fall;

	// odd mode codes are the pwm modes, reserved codes behave as non-pwm
	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = m[0];
	endfunction

	function automatic logic is_fast(input logic [2:0] m);
		is_fast = m[0] & m[1];
	endfunction

	// one waveform bit step; is_a enables the toggle that only channel a has
	function automatic logic wave_next(
		input logic       cur,
		input logic [1:0] act,
		input logic       is_a,
		input logic [2:0] m,
		input logic       match,
		input logic       ign,
		input logic       top_evt,
		input logic       down,
		input logic       force_s
	);
		logic r;
		r = cur;
		if (!is_pwm(m)) begin
			if (match || force_s) begin
				unique case (act)
					2'b00: r = cur;
					2'b01: r = ~cur;
					2'b10: r = 1'b0;
					2'b11: r = 1'b1;
				endcase
			end
		end else if (act == 2'b01) begin
			if (is_a && m[2] && match) begin
				r = ~cur;
			end
		end else if (act[1]) begin
			if (is_fast(m)) begin
				// bottom action follows the top tick, it outranks a match there
				if (top_evt) begin
					r = ~act[0];
				end else if (match && !ign) begin
					r = act[0];
				end
			end else if (top_evt && ign) begin
				r = ~act[0];
			end else if (match && !ign) begin
				r = down ? ~act[0] : act[0];
			end
		end
		wave_next = r;
	endfunction

	// register read decode; reserved and strobe bits always return zero
	function automatic logic [7:0] read_mux(
		input logic [7:0]            a,
		input timer8_pkg::state_type s
	);
		unique case (a)
			`TMR_OFS_CTRL_A: read_mux = {s.ctrl.out_action_a, s.ctrl.out_action_b, 2'b00,
				s.ctrl.waveform_mode_sel[1:0]}; // R6
			`TMR_OFS_CTRL_B: read_mux = {4'h0, s.ctrl.waveform_mode_sel[2],
				s.ctrl.clock_source_sel}; // R6 R12
			`TMR_OFS_COUNT:  read_mux = s.counter_value; // R17
			`TMR_OFS_CMP_A:  read_mux = s.cmp_a_buf;
			`TMR_OFS_CMP_B:  read_mux = s.cmp_b_buf;
			`TMR_OFS_FLAGS:  read_mux = {5'h00, s.flags};
			default:         read_mux = 8'h00;
		endcase
	endfunction

	// next-state logic for the whole block
	always_comb begin
		logic [2:0] m;
		logic [2:0] set_f;
		logic [2:0] clr_f;
		logic       ign_a;
		logic       ign_b;
		s_d   = s_q;
		m     = s_q.ctrl.waveform_mode_sel; // R7
		set_f = 3'h0;
		clr_f = vec_ack_i;
		ign_a = 1'b0;
		ign_b = 1'b0;

		// external pin: two flops, then a third only for the edge compare
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_count_in_i}; // R22
		ext_rise = s_q.ext_sync[1] & ~s_q.ext_sync[2]; // R16
		ext_fall = ~s_q.ext_sync[1] & s_q.ext_sync[2];

		// free-running prescaler, taps give one-cycle enables
		s_d.pre = s_q.pre + 10'h001;
		unique case (s_q.ctrl.clock_source_sel)
			`TMR_CS_STOP:     tick = 1'b0; // R14
			`TMR_CS_DIV1:     tick = 1'b1;
			`TMR_CS_DIV8:     tick = &s_q.pre[`TMR_DIV8_BITS-1:0];
			`TMR_CS_DIV64:    tick = &s_q.pre[`TMR_DIV64_BITS-1:0];
			`TMR_CS_DIV256:   tick = &s_q.pre[`TMR_DIV256_BITS-1:0];
			`TMR_CS_DIV1024:  tick = &s_q.pre[`TMR_DIV1024_BITS-1:0];
			`TMR_CS_EXT_FALL: tick = ext_fall; // R15
			`TMR_CS_EXT_RISE: tick = ext_rise; // R15
		endcase

		// top source: compare a in ctc and the two compare-a pwm modes
		if (m == `TMR_WGM_CTC || m == `TMR_WGM_PC_A || m == `TMR_WGM_FAST_A) begin
			top = s_q.cmp_a; // R8
		end else begin
			top = `TMR_MAX; // R10
		end
		at_top = tick && (s_q.counter_value == top);

		// compare runs every cycle, the match counts on a tick not blocked
		match_a = tick && !s_q.block && (s_q.counter_value == s_q.cmp_a); // R18 R19
		match_b = tick && !s_q.block && (s_q.counter_value == s_q.cmp_b); // R18 R19
		ign_a   = is_pwm(m) && s_q.ctrl.out_action_a[1] && (s_q.cmp_a == top);
		ign_b   = is_pwm(m) && s_q.ctrl.out_action_b[1] && (s_q.cmp_b == top); // R5

		// force strobes act only outside the pwm modes
		force_a = bus_i.wr && bus_i.addr == `TMR_OFS_CTRL_B
			&& bus_i.wdata[`TMR_CB_FORCE_A] && !is_pwm(m); // R11
		force_b = bus_i.wr && bus_i.addr == `TMR_OFS_CTRL_B
			&& bus_i.wdata[`TMR_CB_FORCE_B] && !is_pwm(m); // R11
		wr_cnt  = bus_i.wr && bus_i.addr == `TMR_OFS_COUNT;

		// waveform outputs from the actions in force before this write
		s_d.wave_a = wave_next(s_q.wave_a, s_q.ctrl.out_action_a, 1'b1, m, match_a,
			ign_a, at_top, s_q.dir == timer8_pkg::CNT_DOWN, force_a);
		s_d.wave_b = wave_next(s_q.wave_b, s_q.ctrl.out_action_b, 1'b0, m, match_b,
			ign_b, at_top, s_q.dir == timer8_pkg::CNT_DOWN, force_b); // R2 R3 R4
		s_d.oe_a = (s_q.ctrl.out_action_a != 2'b00) && pin_dir_a_i;
		s_d.oe_b = (s_q.ctrl.out_action_b != 2'b00) && pin_dir_b_i; // R1

		// counting sequence
		if (tick) begin
			s_d.block = 1'b0;
			if (!is_pwm(m) || is_fast(m)) begin
				s_d.dir = timer8_pkg::CNT_UP;
				s_d.counter_value = at_top ? `TMR_BOTTOM : s_q.counter_value + 8'h01;
			end else if (s_q.dir == timer8_pkg::CNT_UP) begin
				if (at_top) begin
					s_d.dir = timer8_pkg::CNT_DOWN; // R21
					s_d.counter_value = (top == `TMR_BOTTOM) ? top : top - 8'h01;
				end else begin
					s_d.counter_value = s_q.counter_value + 8'h01;
				end
			end else if (s_q.counter_value == `TMR_BOTTOM) begin
				s_d.dir = timer8_pkg::CNT_UP;
				s_d.counter_value = 8'h01;
			end else begin
				s_d.counter_value = s_q.counter_value - 8'h01;
			end
		end

		// overflow flag point depends on the mode
		if (is_pwm(m) && !is_fast(m)) begin
			set_f[`TMR_FL_OVF] = tick && s_q.dir == timer8_pkg::CNT_DOWN
				&& s_q.counter_value == `TMR_BOTTOM; // R9
		end else if (m == `TMR_WGM_FAST_A) begin
			set_f[`TMR_FL_OVF] = at_top; // R9
		end else begin
			set_f[`TMR_FL_OVF] = tick && s_q.counter_value == `TMR_MAX; // R8
		end
		set_f[`TMR_FL_MATCH_A] = match_a; // R20
		set_f[`TMR_FL_MATCH_B] = match_b; // R20

		// compare buffers: immediate, at top, or at bottom
		if (!is_pwm(m) || at_top) begin
			s_d.cmp_a = s_q.cmp_a_buf; // R8 R9
			s_d.cmp_b = s_q.cmp_b_buf;
		end

		// register writes
		if (bus_i.wr) begin
			unique case (bus_i.addr)
				`TMR_OFS_CTRL_A: begin
					s_d.ctrl.out_action_a = bus_i.wdata[`TMR_CA_ACT_A_HI:`TMR_CA_ACT_A_LO];
					s_d.ctrl.out_action_b = bus_i.wdata[`TMR_CA_ACT_B_HI:`TMR_CA_ACT_B_LO];
					s_d.ctrl.waveform_mode_sel[1:0] =
						bus_i.wdata[`TMR_CA_WGM_HI:`TMR_CA_WGM_LO]; // R7
				end
				`TMR_OFS_CTRL_B: begin
					s_d.ctrl.waveform_mode_sel[2] = bus_i.wdata[`TMR_CB_WGM2]; // R7
					s_d.ctrl.clock_source_sel = bus_i.wdata[`TMR_CB_CS_HI:`TMR_CB_CS_LO];
				end
				`TMR_OFS_COUNT: begin
					s_d.counter_value = bus_i.wdata; // R17
					s_d.block = 1'b1; // R18
				end
				`TMR_OFS_CMP_A: s_d.cmp_a_buf = bus_i.wdata;
				`TMR_OFS_CMP_B: s_d.cmp_b_buf = bus_i.wdata;
				`TMR_OFS_FLAGS: clr_f = clr_f | bus_i.wdata[2:0];
				default: ;
			endcase
		end

		// a flag set in the clearing cycle survives
		s_d.flags = (s_q.flags & ~clr_f) | set_f; // R20
		s_d.rdata = bus_i.rd ? read_mux(bus_i.addr, s_q) : 8'h00;
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flops
	assign rd_data_o    = s_q.rdata;
	assign wave_out_a_o = s_q.wave_a;
	assign wave_out_b_o = s_q.wave_b;
	assign wave_oe_a_o  = s_q.oe_a;
	assign wave_oe_b_o  = s_q.oe_b;
	assign flags_o      = s_q.flags;

	// checks on the behaviour above
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	chk_driver_enable_b: assert property ( // R1
		(s_q.ctrl.out_action_b != 2'b00 && pin_dir_b_i) |=> wave_oe_b_o)
		else $error("channel b driver not enabled");

	chk_toggle_match_b: assert property ( // R2
		(!is_pwm(s_q.ctrl.waveform_mode_sel) && s_q.ctrl.out_action_b == 2'b01
		&& match_b) |=> wave_out_b_o != $past(wave_out_b_o))
		else $error("channel b did not toggle on match");

	chk_fast_bottom_b: assert property ( // R3
		(is_fast(s_q.ctrl.waveform_mode_sel) && s_q.ctrl.out_action_b == 2'b10
		&& at_top) |=> wave_out_b_o)
		else $error("fast pwm channel b not set at bottom");

	chk_phase_up_b: assert property ( // R4
		(s_q.ctrl.waveform_mode_sel == `TMR_WGM_PC_FF && s_q.ctrl.out_action_b == 2'b10
		&& match_b && s_q.dir == timer8_pkg::CNT_UP && s_q.cmp_b != `TMR_MAX)
		|=> !wave_out_b_o)
		else $error("phase pwm channel b not cleared on up match");

	chk_reserved_zero: assert property ( // R6
		(bus_i.rd && (bus_i.addr == `TMR_OFS_CTRL_A || bus_i.addr == `TMR_OFS_CTRL_B))
		|=> (($past(bus_i.addr) == `TMR_OFS_CTRL_A) ? (rd_data_o[3:2] == 2'b00)
		: (rd_data_o[7:4] == 4'h0)))
		else $error("reserved control bits read nonzero");

	chk_force_noflag: assert property ( // R12
		((force_a || force_b) && !tick && vec_ack_i == 3'h0) |=> flags_o == $past(flags_o))
		else $error("force strobe changed a flag");

	chk_stop_hold: assert property ( // R14
		(s_q.ctrl.clock_source_sel == `TMR_CS_STOP && !wr_cnt)
		|=> s_q.counter_value == $past(s_q.counter_value))
		else $error("stopped counter moved");

	chk_ext_edge: assert property ( // R15
		(s_q.ctrl.clock_source_sel == `TMR_CS_EXT_RISE) |-> tick == ext_rise)
		else $error("external rising edge not taken as tick");

	chk_write_block: assert property ( // R18
		wr_cnt ##1 (tick && !wr_cnt) |-> !match_a && !match_b)
		else $error("match not suppressed after counter write");

	chk_phase_turn: assert property ( // R21
		(s_q.ctrl.waveform_mode_sel == `TMR_WGM_PC_FF && at_top && !wr_cnt
		&& s_q.dir == timer8_pkg::CNT_UP)
		|=> s_q.counter_value == 8'hfe && s_q.dir == timer8_pkg::CNT_DOWN)
		else $error("phase counter did not turn at top");

	chk_set_wins: assert property ( // R20
		(match_a && vec_ack_i[`TMR_FL_MATCH_A]) |=> flags_o[`TMR_FL_MATCH_A])
		else $error("match flag lost against clear");

	// main scenarios
	cov_ctc_wrap: cover property (
		s_q.ctrl.waveform_mode_sel == `TMR_WGM_CTC && at_top ##1
		s_q.counter_value == `TMR_BOTTOM);
	cov_phase_bottom: cover property (
		s_q.dir == timer8_pkg::CNT_DOWN ##1 s_q.dir == timer8_pkg::CNT_UP);
	cov_force_apply: cover property (force_b ##1 wave_out_b_o != $past(wave_out_b_o));

endmodule // timer8_compare_pwm_unit

// ---- bench/pin_side_model.sv ----
module pin_side_model (
	// clock and command from the bench
	input  wire logic mclk_i,
	input  wire logic go_i,
	// count pin and status
	output logic      ext_count_o,
	output logic      busy_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] step_q = 4'h0;

	// one pulse is 4 cycles high, 6 low, so both edges outlive the pin synchroniser
	always_ff @(posedge mclk_i) begin
		if (go_i && step_q == 4'h0) begin
			step_q <= 4'h1;
		end else if (step_q != 4'h0) begin
			step_q <= (step_q == 4'ha) ? 4'h0 : step_q + 4'h1;
		end
	end

	// pin idles low between pulses; the model drives it at all times
	assign ext_count_o = (step_q >= 4'h1) && (step_q <= 4'h4);
	assign busy_o      = (step_q != 4'h0);
endmodule // pin_side_model

// ---- bench/tb_timer8_compare_pwm_unit.sv ----
`include "timer8_map.svh"

module tb_timer8_compare_pwm_unit;
	timeunit 1ns;
	timeprecision 1ps;

	logic                    mclk_i    = 1'b0;
	logic                    rst_i     = 1'b1;
	timer8_pkg::bus_req_type bus_q     = '0;
	logic                    go_q      = 1'b0;
	logic                    dir_b_q   = 1'b0;
	logic [2:0]              vec_ack_q = 3'h0;
	logic [7:0]              rd_data;
	logic                    ext_pin;
	logic                    busy;
	logic                    wave_a;
	logic                    wave_b;
	logic                    oe_a;
	logic                    oe_b;
	logic [2:0]              flags;
	logic                    exp_w;
	int                      failures  = 0;
	int                      n_checks  = 0;
	int                      shifts [6] = '{0, 0, 3, 6, 8, 10};

	timer8_compare_pwm_unit uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_q), .rd_data_o(rd_data),
		.ext_count_in_i(ext_pin), .pin_dir_a_i(1'b0), .pin_dir_b_i(dir_b_q),
		.wave_out_a_o(wave_a), .wave_out_b_o(wave_b), .wave_oe_a_o(oe_a),
		.wave_oe_b_o(oe_b), .vec_ack_i(vec_ack_q), .flags_o(flags)
	);

	pin_side_model pins (.mclk_i(mclk_i), .go_i(go_q), .ext_count_o(ext_pin), .busy_o(busy));

	// 200 MHz clock
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// bus cycles start after an edge, so back-to-back calls never drive twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_q <= '0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_q <= '0;
		#1 check(rd_data, exp);
	endtask

	task automatic ack(input logic [2:0] m);
		@(posedge mclk_i);
		vec_ack_q <= m;
		@(posedge mclk_i);
		vec_ack_q <= 3'h0;
	endtask

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			go_q <= 1'b1;
			@(posedge mclk_i);
			go_q <= 1'b0;
			@(posedge mclk_i);
			for (int i = 0; i < 20 && busy; i++) @(posedge mclk_i);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// watchdog sized at about three and a half times the expected run
	initial begin
		#300000;
		failures++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_i   <= 1'b0;
		dir_b_q <= 1'b1;
		for (int a = 'h24; a <= 'h2a; a++) rdchk(8'(a), 8'h00);
		check({7'h00, oe_b}, 8'h00);
		wr(`TMR_OFS_CTRL_A, 8'hff);
		rdchk(`TMR_OFS_CTRL_A, 8'hf3);
		check({7'h00, oe_a}, 8'h00);
		wr(`TMR_OFS_CTRL_B, 8'h38);
		rdchk(`TMR_OFS_CTRL_B, 8'h08);
		wr(`TMR_OFS_CTRL_A, 8'h00);
		// each window but the stopped one holds exactly ten ticks, whatever the prescaler phase
		for (int s = 0; s < 6; s++) begin
			wr(`TMR_OFS_CTRL_B, 8'(s));
			wr(`TMR_OFS_COUNT, 8'h00);
			repeat ((10 << shifts[s]) - 1) @(posedge mclk_i);
			rdchk(`TMR_OFS_COUNT, (s == 0) ? 8'h00 : 8'h0a);
		end
		wr(`TMR_OFS_CTRL_B, 8'h06);
		wr(`TMR_OFS_COUNT, 8'h00);
		pulse(3);
		rdchk(`TMR_OFS_COUNT, 8'h03);
		wr(`TMR_OFS_CTRL_B, 8'h07);
		wr(`TMR_OFS_COUNT, 8'h02);
		pulse(1);
		rdchk(`TMR_OFS_COUNT, 8'h03);
		wr(`TMR_OFS_CMP_B, 8'h02);
		wr(`TMR_OFS_FLAGS, 8'h07);
		// counter written to 2: the blocked tick must not match
		wr(`TMR_OFS_COUNT, 8'h02);
		pulse(1);
		rdchk(`TMR_OFS_FLAGS, 8'h00);
		// non-pwm actions toggle, clear, set; stepping by the count pin
		exp_w = 1'b0;
		for (int c = 1; c < 4; c++) begin
			wr(`TMR_OFS_CTRL_A, 8'(c << 4));
			wr(`TMR_OFS_COUNT, 8'h01);
			pulse(2);
			exp_w = (c == 1) ? ~exp_w : (c == 3);
			rdchk(`TMR_OFS_FLAGS, 8'h04);
			check({7'h00, wave_b}, {7'h00, exp_w});
			check({7'h00, oe_b}, 8'h01);
			if (c == 2) ack(3'h4);
			else wr(`TMR_OFS_FLAGS, 8'h04);
			#1 check({5'h00, flags}, 8'h00);
		end
		// force strobe toggles without flag or counter change
		wr(`TMR_OFS_CTRL_A, 8'h10);
		wr(`TMR_OFS_CTRL_B, 8'h47);
		rdchk(`TMR_OFS_CTRL_B, 8'h07);
		check({7'h00, wave_b}, 8'h00);
		rdchk(`TMR_OFS_FLAGS, 8'h00);
		rdchk(`TMR_OFS_COUNT, 8'h03);
		// fast pwm inverting: set at match, clear at bottom, overflow at max
		wr(`TMR_OFS_CTRL_A, 8'h33);
		wr(`TMR_OFS_CTRL_B, 8'h07);
		wr(`TMR_OFS_COUNT, 8'h01);
		pulse(2);
		check({7'h00, wave_b}, 8'h01);
		wr(`TMR_OFS_COUNT, 8'hfe);
		pulse(2);
		check({7'h00, wave_b}, 8'h00);
		rdchk(`TMR_OFS_FLAGS, 8'h05);
		rdchk(`TMR_OFS_COUNT, 8'h00);
		wr(`TMR_OFS_FLAGS, 8'h07);
		// phase correct inverting: set on up match, clear on down match
		wr(`TMR_OFS_CTRL_A, 8'h31);
		wr(`TMR_OFS_COUNT, 8'h01);
		pulse(2);
		check({7'h00, wave_b}, 8'h01);
		wr(`TMR_OFS_COUNT, 8'hfe);
		pulse(2);
		rdchk(`TMR_OFS_COUNT, 8'hfe);
		pulse(253);
		check({7'h00, wave_b}, 8'h00);
		rdchk(`TMR_OFS_COUNT, 8'h01);
		pulse(2);
		rdchk(`TMR_OFS_FLAGS, 8'h07);
		check({7'h00, wave_a}, 8'h00);
		tally_and_finish();
	end
endmodule // tb_timer8_compare_pwm_unit
